// ---- pkg/pwb_pkg.sv ----
/*
 * Constants, register map and carrier types of the eight-channel
 * pulse-width / rate-multiplier DAC generator.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package pwb_pkg;

   // ==========================================================
   // Sizes
   localparam int unsigned NUM_CH     = 8;
   localparam int unsigned CNT_W      = 12;
   localparam int unsigned PW_W       = 6;
   localparam int unsigned RM_W       = 4;
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned DATA_W     = 32;

   // ==========================================================
   // Counter fields
   localparam int unsigned PW_LSB     = 0;
   localparam int unsigned IDX_LSB    = 6;
   localparam int unsigned IDX_W      = 4;

   // ==========================================================
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_WT_CH1  = 8'h32;
   localparam logic [7:0] IDX_RM_21   = 8'h33;
   localparam logic [7:0] IDX_WT_CH2  = 8'h34;
   localparam logic [7:0] IDX_WT_CH3  = 8'h35;
   localparam logic [7:0] IDX_RM_43   = 8'h36;
   localparam logic [7:0] IDX_WT_CH4  = 8'h37;
   localparam logic [7:0] IDX_WT_CH5  = 8'h38;
   localparam logic [7:0] IDX_RM_65   = 8'h39;
   localparam logic [7:0] IDX_WT_CH6  = 8'h3A;
   localparam logic [7:0] IDX_WT_CH7  = 8'h3B;
   localparam logic [7:0] IDX_RM_87   = 8'h3C;
   localparam logic [7:0] IDX_WT_CH8  = 8'h3D;
   localparam logic [7:0] IDX_OE      = 8'h3E;
   localparam logic [7:0] IDX_OD      = 8'h3F;

   // ==========================================================
   // Weight register fields and reset values
   localparam int unsigned POL_BIT    = 6;
   localparam int unsigned RSV_BIT    = 7;
   localparam logic [6:0] WT_RST      = 7'h00;
   localparam logic [7:0] RM_RST      = 8'h00;
   localparam logic [7:0] OE_RST      = 8'h80;
   localparam logic [7:0] OD_RST      = 8'h00;

   // ==========================================================
   // Decoder selector codes
   localparam logic [3:0] SEL_RM0     = 4'h8;
   localparam logic [3:0] SEL_OE      = 4'hC;
   localparam logic [3:0] SEL_OD      = 4'hD;
   localparam logic [3:0] SEL_NONE    = 4'hF;

   // ==========================================================
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Pin group: level and drive enable per channel
   typedef struct packed {
      logic [NUM_CH-1:0] level;
      logic [NUM_CH-1:0] drive;
   } pwb_pins_s;

endpackage

// ---- hw/pwb_dac.sv ----
/*
 * Eight-channel 10-bit pulse-width / rate-multiplier DAC generator
 * with an AXI4-Lite register slave.
 * Assumes one clock, an external RC filter on each pin and a pad
 * that resolves level and drive into the wire.
 */
`timescale 1ns/1ps

module pwb_dac
   import pwb_pkg::*;
(
   input  wire logic              SYS_CLK,
   input  wire logic              RESET_N,
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic              S_AXI_AWVALID,
   output logic                   S_AXI_AWREADY,
   input  wire logic [DATA_W-1:0] S_AXI_WDATA,
   input  wire logic [3:0]        S_AXI_WSTRB,
   input  wire logic              S_AXI_WVALID,
   output logic                   S_AXI_WREADY,
   output logic [1:0]             S_AXI_BRESP,
   output logic                   S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY,
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic              S_AXI_ARVALID,
   output logic                   S_AXI_ARREADY,
   output logic [DATA_W-1:0]      S_AXI_RDATA,
   output logic [1:0]             S_AXI_RRESP,
   output logic                   S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY,
   output pwb_pins_s              PWM_PIN
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [CNT_W-1:0]          cnt;
      logic [NUM_CH-1:0][6:0]    wt;
      logic [NUM_CH/2-1:0][7:0]  rm;
      logic [7:0]                oe;
      logic [7:0]                od;
      logic [NUM_CH-1:0]         lvl;
      logic [NUM_CH-1:0]         drv;
      logic                      aw_v;
      logic [ADDR_W-1:0]         aw_a;
      logic                      w_v;
      logic [7:0]                w_d;
      logic                      w_s;
      logic                      bvalid;
      logic [1:0]                bresp;
      logic                      rvalid;
      logic [7:0]                rdata;
      logic [1:0]                rresp;
   } pwb_state_s;

   pwb_state_s st_r;
   pwb_state_s st_nxt;

   // ==========================================================
   // Address decode, shared by write and read paths
   // Returns 0..7 weight channel, 8..11 rate pair, OE, OD or none.
   function automatic logic [3:0] pwb_sel(input logic [ADDR_W-1:0] a);
      logic [5:0] i;
      i = a[7:2];
      if (a[1:0] != 2'h0) begin
         pwb_sel = SEL_NONE;
      end else if (i == IDX_WT_CH1[5:0]) begin
         pwb_sel = 4'h0;
      end else if (i == IDX_WT_CH2[5:0]) begin
         pwb_sel = 4'h1;
      end else if (i == IDX_WT_CH3[5:0]) begin
         pwb_sel = 4'h2;
      end else if (i == IDX_WT_CH4[5:0]) begin
         pwb_sel = 4'h3;
      end else if (i == IDX_WT_CH5[5:0]) begin
         pwb_sel = 4'h4;
      end else if (i == IDX_WT_CH6[5:0]) begin
         pwb_sel = 4'h5;
      end else if (i == IDX_WT_CH7[5:0]) begin
         pwb_sel = 4'h6;
      end else if (i == IDX_WT_CH8[5:0]) begin
         pwb_sel = 4'h7;
      end else if (i == IDX_RM_21[5:0]) begin
         pwb_sel = 4'h8;
      end else if (i == IDX_RM_43[5:0]) begin
         pwb_sel = 4'h9;
      end else if (i == IDX_RM_65[5:0]) begin
         pwb_sel = 4'hA;
      end else if (i == IDX_RM_87[5:0]) begin
         pwb_sel = 4'hB;
      end else if (i == IDX_OE[5:0]) begin
         pwb_sel = SEL_OE;
      end else if (i == IDX_OD[5:0]) begin
         pwb_sel = SEL_OD;
      end else begin
         pwb_sel = SEL_NONE;
      end
   endfunction

   // ==========================================================
   // Rate multiplier: does this cycle get the extra clock
   function automatic logic pwb_add(input logic [IDX_W-1:0] idx,
                                    input logic [RM_W-1:0]  rm);
      logic [RM_W-1:0] hit;
      hit[0] = (idx == 4'h8);
      hit[1] = (idx[2:0] == 3'h4);
      hit[2] = (idx[1:0] == 2'h2);
      hit[3] = idx[0];
      // Cycle 0 matches no pattern, so it never gets the extra clock
      pwb_add = |(hit & rm);
   endfunction

   // ==========================================================
   // Register write for a decoded selector; lane 0 only
   function automatic pwb_state_s pwb_wr(input logic [3:0] sel,
                                         input logic [7:0] d,
                                         input pwb_state_s s);
      pwb_state_s n;
      n = s;
      if (sel < SEL_RM0) begin
         // Bit 7 has no storage, so writes to it are dropped
         n.wt[sel[2:0]] = d[6:0];
      end else if (sel < SEL_OE) begin
         n.rm[sel[1:0]] = d;
      end else if (sel == SEL_OE) begin
         n.oe = d;
      end else if (sel == SEL_OD) begin
         n.od = d;
      end
      pwb_wr = n;
   endfunction

   // ==========================================================
   // Read data for a decoded selector; bit 7 of a weight reads one
   function automatic logic [7:0] pwb_rd_byte(input logic [3:0] sel,
                                              input pwb_state_s s);
      logic [7:0] b;
      b = 8'h00;
      if (sel < SEL_RM0) begin
         b = {1'b1, s.wt[sel[2:0]]};
      end else if (sel < SEL_OE) begin
         b = s.rm[sel[1:0]];
      end else if (sel == SEL_OE) begin
         b = s.oe;
      end else if (sel == SEL_OD) begin
         b = s.od;
      end else begin
         // Unmapped reads return zero beside the error response
         b = 8'h00;
      end
      pwb_rd_byte = b;
   endfunction

   // ==========================================================
   // Per-channel waveform and pad drive
   logic [PW_W-1:0]   pw_cnt;
   logic [IDX_W-1:0]  cyc_idx;
   logic [NUM_CH-1:0] wave;
   logic [NUM_CH-1:0] pin_lvl;
   logic [NUM_CH-1:0] pin_drv;

   assign pw_cnt  = st_r.cnt[PW_LSB +: PW_W];
   assign cyc_idx = st_r.cnt[IDX_LSB +: IDX_W];

   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
         logic [RM_W-1:0] rm_f;
         logic [PW_W-1:0] wt_f;
         logic            polarity_invert;
         logic            ext;
         logic            hi_base;
         logic            hi_ext;
         logic            sig;
         logic            lvl_c;
         logic            drv_c;
         assign rm_f    = st_r.rm[g/2][(g%2)*RM_W +: RM_W];
         assign wt_f    = st_r.wt[g][PW_W-1:0];
         assign polarity_invert     = st_r.wt[g][POL_BIT];
         assign ext     = pwb_add(cyc_idx, rm_f);
         // Set at the wrap of the low bits, cleared at the match
         assign hi_base = (pw_cnt < wt_f);
         // The extra clock keeps the pulse up through the match
         // count, so full weight with the extra never drops
         assign hi_ext  = (pw_cnt <= wt_f);
         assign wave[g] = ext ? hi_ext : hi_base;
         assign sig     = wave[g] ^ polarity_invert;

         // A disabled pin is released; open drain only pulls low
         // and relies on the board pull-up for the high level
         always_comb begin
            if (!st_r.oe[g]) begin
               lvl_c = 1'b0;
               drv_c = 1'b0;
            end else if (st_r.od[g]) begin
               lvl_c = 1'b0;
               drv_c = !sig;
            end else begin
               lvl_c = sig;
               drv_c = 1'b1;
            end
         end
         assign pin_lvl[g] = lvl_c;
         assign pin_drv[g] = drv_c;
      end
   endgenerate

   // ==========================================================
   // Next state
   always_comb begin
      logic [3:0] ws;
      logic [3:0] rs;
      st_nxt = st_r;
      ws = pwb_sel(st_r.aw_a);
      rs = pwb_sel(S_AXI_ARADDR);

      // Counter and pins
      st_nxt.cnt = st_r.cnt + 12'h001;
      // Pins are registered so the pad sees no decode glitches,
      // at the cost of one clock of lag behind the counter
      st_nxt.lvl = pin_lvl;
      st_nxt.drv = pin_drv;

      // Write channel: address and data are caught in either order
      if (S_AXI_AWVALID && !st_r.aw_v) begin
         st_nxt.aw_v = 1'b1;
         st_nxt.aw_a = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !st_r.w_v) begin
         st_nxt.w_v = 1'b1;
         st_nxt.w_d = S_AXI_WDATA[7:0];
         st_nxt.w_s = S_AXI_WSTRB[0];
      end
      if (st_r.bvalid && S_AXI_BREADY) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.aw_v && st_r.w_v && !st_r.bvalid) begin
         st_nxt.aw_v   = 1'b0;
         st_nxt.w_v    = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = (ws == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         // Only lane 0 carries register bits; other lanes ignored
         if (st_r.w_s) begin
            st_nxt = pwb_wr(ws, st_r.w_d, st_nxt);
         end
      end

      // Read channel: one word held until the master takes it
      if (st_r.rvalid && S_AXI_RREADY) begin
         st_nxt.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && !st_r.rvalid) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = (rs == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         st_nxt.rdata  = pwb_rd_byte(rs, st_r);
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         // Pins come up released; OE_RST enables channel 8, which drives low from the next clock
         st_r.cnt    <= '0;
         st_r.lvl    <= '0;
         st_r.drv    <= '0;
         st_r.aw_v   <= 1'b0;
         st_r.aw_a   <= '0;
         st_r.w_v    <= 1'b0;
         st_r.w_d    <= '0;
         st_r.w_s    <= 1'b0;
         st_r.bvalid <= 1'b0;
         st_r.bresp  <= '0;
         st_r.rvalid <= 1'b0;
         st_r.rdata  <= '0;
         st_r.rresp  <= '0;
         st_r.wt     <= {NUM_CH{WT_RST}};
         st_r.rm     <= {(NUM_CH/2){RM_RST}};
         st_r.oe     <= OE_RST;
         st_r.od     <= OD_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs
   // Readies are the inverse of the held flags, so a held word
   // blocks the next one until the write answer is issued or the read word is taken
   assign S_AXI_AWREADY = !st_r.aw_v;
   assign S_AXI_WREADY  = !st_r.w_v;
   assign S_AXI_BVALID  = st_r.bvalid;
   assign S_AXI_BRESP   = st_r.bresp;
   assign S_AXI_ARREADY = !st_r.rvalid;
   assign S_AXI_RVALID  = st_r.rvalid;
   assign S_AXI_RRESP   = st_r.rresp;
   assign S_AXI_RDATA   = {24'h000000, st_r.rdata};
   assign PWM_PIN.level = st_r.lvl;
   assign PWM_PIN.drive = st_r.drv;

endmodule

// ---- testbench/pwb_dac_sva.sv ----
/*
 * Bus and pin checker for the PWM / rate-multiplier DAC block.
 * Assumes one clock domain and the top module's ports only.
 */
`timescale 1ns/1ps
module pwb_dac_sva
   import pwb_pkg::*;
(
   input wire logic              SYS_CLK,
   input wire logic              RESET_N,
   input wire logic              S_AXI_AWVALID,
   input wire logic              S_AXI_AWREADY,
   input wire logic              S_AXI_WVALID,
   input wire logic              S_AXI_WREADY,
   input wire logic [1:0]        S_AXI_BRESP,
   input wire logic              S_AXI_BVALID,
   input wire logic              S_AXI_BREADY,
   input wire logic              S_AXI_ARVALID,
   input wire logic              S_AXI_ARREADY,
   input wire logic [DATA_W-1:0] S_AXI_RDATA,
   input wire logic              S_AXI_RVALID,
   input wire logic              S_AXI_RREADY,
   input wire pwb_pins_s         PWM_PIN
);
   // ==========================================================
   // Clocking
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   sequence s_wr_taken;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence s_wr_answer;
      ##[1:2] S_AXI_BVALID;
   endsequence
   // ==========================================================
   // Properties
   a_write_answer: assert property (s_wr_taken |-> s_wr_answer)
      else $error("write response missing");
   a_aw_drop: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=>
      !S_AXI_AWREADY) else $error("write address accepted twice");
   a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write resp lost");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
      S_AXI_RVALID) else $error("read data late");
   a_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data lost");
   a_arready_inv: assert property (S_AXI_ARREADY == !S_AXI_RVALID)
      else $error("read ready wrong");
   a_rdata_upper: assert property (S_AXI_RVALID |->
      S_AXI_RDATA[31:8] == 24'h0) else $error("read upper bits set");
   a_pin_release: assert property (
      (PWM_PIN.level & ~PWM_PIN.drive) == 8'h00) else $error("pin level");
endmodule

bind pwb_dac pwb_dac_sva u_sva (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .PWM_PIN(PWM_PIN));

// ---- testbench/pwb_rc_load.sv ----
/*
 * Pad and RC load on each DAC pin, with a board pull-up.
 * Assumes level and drive come straight from the block.
 */
`timescale 1ns/1ps
module pwb_rc_load
   import pwb_pkg::*;
(
   input  wire pwb_pins_s         pins,
   output wire logic [NUM_CH-1:0] pin_wire
);
   // ==========================================================
   // Wire level: a released pin is pulled high, never left floating
   assign pin_wire = (pins.drive & pins.level) | ~pins.drive;
endmodule

// ---- testbench/tb_top.sv ----
/*
 * Register and duty tests of the PWM / rate-multiplier DAC block.
 * Assumes the pull-up pad model; duty is counted over 1024 clocks.
 */
`timescale 1ns/1ps
module tb_top
   import pwb_pkg::*;
;
   logic              sys_clk = 1'b0, reset_n = 1'b0;
   logic [7:0]        awaddr = 8'h00, araddr = 8'h00;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic              arvalid = 1'b0, rready = 1'b0;
   logic [31:0]       wdata = 32'h0;
   logic [3:0]        wstrb = 4'h1;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [1:0]        bresp, rresp;
   logic [31:0]       rdata;
   pwb_pins_s         pins;
   logic [NUM_CH-1:0] pin_wire;
   int                n_fail = 0, cmp_count = 0;

   always #5 sys_clk = ~sys_clk;
   pwb_dac dut (.SYS_CLK(sys_clk), .RESET_N(reset_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PWM_PIN(pins));
   pwb_rc_load u_load (.pins(pins), .pin_wire(pin_wire));

   // ==========================================================
   // Bus tasks
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] i, d, output logic [1:0] r);
      @(posedge sys_clk);
      awaddr <= {i[5:0], 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] i, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge sys_clk);
      araddr <= {i[5:0], 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   function automatic logic [7:0] rst_val(input logic [7:0] i);
      if (i == IDX_OE) return 8'h80;
      if (i == IDX_OD || i == IDX_RM_21 || i == IDX_RM_43) return 8'h00;
      if (i == IDX_RM_65 || i == IDX_RM_87) return 8'h00;
      return 8'h80;
   endfunction
   // Duty over 1024 clocks is 16 x weight plus the rate value
   task automatic run(input string nm, input logic [7:0] wi, wt, rm,
                      input int ch, input logic [10:0] exp);
      logic [1:0]  r;
      logic [10:0] h;
      wr(wi, wt, r);
      wr(IDX_RM_21, rm, r);
      repeat (4) @(posedge sys_clk);
      h = 11'h0;
      repeat (1024) begin
         @(posedge sys_clk);
         h = h + 11'(pin_wire[ch]);
      end
      chk(nm, 32'(h), 32'(exp));
      $display("test %s done", nm);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // ==========================================================
   // Tests
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int i = 8'h32; i <= 8'h3F; i++) begin
         rd(8'(i), d, r);
         chk("reset value", d, {24'h0, rst_val(8'(i))});
      end
      wr(IDX_WT_CH1, 8'h45, r);
      rd(IDX_WT_CH1, d, r);
      chk("weight readback", d, 32'h000000C5);
      rd(8'h00, d, r);
      chk("unmapped read", 32'(r), 32'(RESP_SLVERR));
      wr(8'h00, 8'h12, r);
      chk("unmapped write", 32'(r), 32'(RESP_SLVERR));
      $display("test registers done");
      wr(IDX_OE, 8'hFF, r);
      run("zero", IDX_WT_CH1, 8'h00, 8'h00, 0, 11'h000);
      run("example", IDX_WT_CH1, 8'h18, 8'h06, 0, 11'h186);
      run("full", IDX_WT_CH1, 8'h3F, 8'h0F, 0, 11'h3FF);
      run("static high", IDX_WT_CH1, 8'h40, 8'h00, 0, 11'h400);
      run("inverted", IDX_WT_CH1, 8'h5F, 8'h00, 0, 11'h210);
      for (int k = 0; k < 4; k++)
         run("rate code", IDX_WT_CH1, 8'h05, 8'(1 << k), 0,
             11'h50 + 11'(1 << k));
      wr(IDX_OD, 8'h01, r);
      run("open drain", IDX_WT_CH1, 8'h18, 8'h06, 0, 11'h186);
      wr(IDX_OE, 8'hFE, r);
      run("disabled", IDX_WT_CH1, 8'h18, 8'h06, 0, 11'h400);
      run("upper nibble", IDX_WT_CH2, 8'h0A, 8'h30, 1, 11'h0A3);
      results();
   end
   initial begin
      repeat (40000) @(posedge sys_clk);
      n_fail++;
      results();
   end
endmodule
